// [hw/coeff_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module coeff_mem
  import dac_ctrl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Access port
  coeff_mem_if.mem port
);

  // Contents hold no reset so the array maps onto plain memory.
  logic [COEFF_WIDTH-1:0] store [COEFF_DEPTH];
  logic [COEFF_WIDTH-1:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rdata_reg <= store[port.addr];
  end

  assign port.rdata = rdata_reg;

endmodule
`default_nettype wire

// [hw/coeff_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface coeff_mem_if;
  import dac_ctrl_pkg::*;
  logic [COEFF_AW-1:0] addr;
  logic we;
  logic [COEFF_WIDTH-1:0] wdata;
  logic [COEFF_WIDTH-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// [hw/dac_ctrl_pkg.sv]
package dac_ctrl_pkg;

  // Byte offsets in the module's I/O space.
  localparam logic [6:0] OFF_CHAN_LAST = 7'h1E;
  localparam logic [6:0] OFF_TRANSPARENT = 7'h20;
  localparam logic [6:0] OFF_SIMULTANEOUS = 7'h22;
  localparam logic [6:0] OFF_UPDATE_TRIGGER = 7'h24;
  localparam logic [6:0] OFF_CHANNEL_WRITE_BUSY = 7'h26;
  localparam logic [6:0] OFF_SOFT_RESET_CONTROL = 7'h28;
  localparam logic [6:0] OFF_COEFF_MEMORY_STATUS = 7'h2A;
  localparam logic [6:0] OFF_COEFF_WRITE_ENABLE = 7'h2B;
  localparam logic [6:0] OFF_COEFF_FIRST = 7'h41;
  localparam logic [6:0] OFF_COEFF_LAST = 7'h7F;

  // Field layout.
  localparam int DAC_BITS = 12;
  localparam int CHAN_DATA_LSB = 4;
  localparam int CTRL_SOFT_RESET_BIT = 7;
  localparam int COEFF_BUSY_BIT = 15;
  localparam logic [1:0] COEFF_WRITE_KEY = 2'h3;
  localparam int COEFF_WIDTH = 8;
  localparam int COEFF_DEPTH = 32;
  localparam int COEFF_AW = 5;

  // Reset values.
  localparam logic [11:0] ZERO_VOLT_CODE = 12'h800;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] COEFF_WEN_RESET = 8'h00;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Timing.
  localparam int CLK_MHZ = 50;
  localparam int CHAN_XFER_NS = 2000;
  localparam logic [7:0] CHAN_XFER_CYC = 8'((CHAN_XFER_NS * CLK_MHZ + 999) / 1000);
  localparam int COEFF_WRITE_US = 1000;
  localparam int COEFF_WRITE_CYC_DEF = COEFF_WRITE_US * CLK_MHZ;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK, BUS_HOLD} bus_state_e;

endpackage

// [hw/dac_update_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - A trigger write makes one update pulse copying all input latches to outputs.
// - Reads of the trigger location get no acknowledge.
// - In simultaneous mode output latches hold until the next trigger or reset.
// - A trigger write is acknowledged after exactly one wait state.
// - The data of a trigger write is ignored.
// - Reset selects simultaneous mode and sets outputs to the zero volt code.
// - Reset clears output latches only; host rewrites input latches afterwards.
// - A trigger in transparent mode also switches to simultaneous mode.
// - Write status bit n drops on a channel n write, rises when transfer ends.
// - Writing one to control bit 7 performs a software reset to zero volts.
// - Control word clears on any reset and takes byte or word accesses.
// - Coefficient writes are taken only while write-control bits 0 and 1 are set.
// - Status bit 15 is low during a coefficient write and high after it.
// - Coefficients read at odd bytes of the window, in low data bits.
// - Coefficients are 8-bit two's complement quarter-LSB values.
// - A coefficient read is acknowledged after exactly one wait state.
// - In transparent mode a channel write goes straight to its output latch.
// - Channel data is 12-bit offset binary in bits 15 to 4.
// - Any write to the transparent select location selects transparent mode.
// - Any write to the simultaneous select location selects simultaneous mode.
module dac_update_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int COEFF_WRITE_CYCLES = COEFF_WRITE_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // I/O space bus
  input wire logic io_sel_n,
  input wire logic rd_wr,
  input wire logic [6:1] addr,
  input wire logic [1:0] byte_sel_n,
  input wire logic [15:0] data_in,
  output logic ack_n,
  output logic [15:0] data_out,
  output logic data_oe_n,
  // Converter side
  output logic [CHANNELS*DAC_BITS-1:0] dac_code,
  output logic update_pulse,
  output logic transparent_mode
);

  coeff_mem_if cif ();

  coeff_mem u_coeff_mem (
    .clk(clk),
    .port(cif.mem)
  );

  bus_state_e state_reg, state_next;
  logic [6:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic [1:0] bs_n_reg, bs_n_next;
  logic [15:0] wdata_reg, wdata_next;
  logic ack_n_reg, ack_n_next;
  logic oe_n_reg, oe_n_next;
  logic [15:0] dout_reg, dout_next;
  logic transp_reg, transp_next;
  logic upd_reg, upd_next;
  logic srst_reg, srst_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [7:0] cwen_reg, cwen_next;
  logic [15:0] cbusy_cnt_reg, cbusy_cnt_next;
  logic [DAC_BITS-1:0] in_latch_reg [CHANNELS];
  logic [DAC_BITS-1:0] in_latch_next [CHANNELS];
  logic [DAC_BITS-1:0] out_latch_reg [CHANNELS];
  logic [DAC_BITS-1:0] out_latch_next [CHANNELS];
  logic [CHANNELS-1:0] chan_start;
  logic [15:0] chan_ready;
  logic coeff_we;

  // Decode of the captured access.
  logic hit_chan;
  logic hit_coeff;
  logic respond;
  logic [3:0] chan_idx;
  logic [15:0] rdata;

  assign hit_chan = (addr_reg <= OFF_CHAN_LAST);
  assign hit_coeff = (addr_reg >= (OFF_COEFF_FIRST & 7'h7E)) && (addr_reg <= OFF_COEFF_LAST);
  assign chan_idx = addr_reg[4:1];
  // Mode and trigger locations stay silent on reads.
  assign respond = !(rd_reg && (addr_reg == OFF_TRANSPARENT || addr_reg == OFF_SIMULTANEOUS ||
                                addr_reg == OFF_UPDATE_TRIGGER));

  // The memory sees the live address while idle so its registered read is ready in the
  // wait state; during the wait state it sees the captured address for a write.
  assign cif.addr = (state_reg == BUS_IDLE) ? addr[5:1] : addr_reg[5:1];
  assign cif.wdata = wdata_reg[COEFF_WIDTH-1:0];
  assign cif.we = coeff_we;

  always_comb begin
    rdata = READ_ZERO;
    if (hit_chan) begin
      rdata[15:CHAN_DATA_LSB] = in_latch_reg[chan_idx];
    end else if (hit_coeff) begin
      // Signed quarter-LSB bytes appear unaltered in the low lane.
      rdata[COEFF_WIDTH-1:0] = cif.rdata;
    end else if (addr_reg == OFF_CHANNEL_WRITE_BUSY) begin
      rdata = chan_ready;
    end else if (addr_reg == OFF_SOFT_RESET_CONTROL) begin
      rdata = ctrl_reg;
    end else if (addr_reg == OFF_COEFF_MEMORY_STATUS) begin
      rdata[COEFF_BUSY_BIT] = (cbusy_cnt_reg == 16'h0000);
      rdata[7:0] = cwen_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    bs_n_next = bs_n_reg;
    wdata_next = wdata_reg;
    ack_n_next = 1'b1;
    oe_n_next = 1'b1;
    dout_next = dout_reg;
    transp_next = transp_reg;
    upd_next = 1'b0;
    srst_next = 1'b0;
    ctrl_next = ctrl_reg;
    cwen_next = cwen_reg;
    cbusy_cnt_next = (cbusy_cnt_reg != 16'h0000) ? cbusy_cnt_reg - 16'h0001 : cbusy_cnt_reg;
    in_latch_next = in_latch_reg;
    out_latch_next = out_latch_reg;
    chan_start = '0;
    coeff_we = 1'b0;
    unique case (state_reg)
      BUS_IDLE: begin
        if (!io_sel_n) begin
          addr_next = {addr, 1'b0};
          rd_next = rd_wr;
          bs_n_next = byte_sel_n;
          wdata_next = data_in;
          state_next = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        // This cycle is the single wait state before the acknowledge.
        if (!rd_reg) begin
          if (hit_chan) begin
            chan_start[chan_idx] = 1'b1;
            in_latch_next[chan_idx] = wdata_reg[15:CHAN_DATA_LSB];
            if (transp_reg) begin
              out_latch_next[chan_idx] = wdata_reg[15:CHAN_DATA_LSB];
            end
          end else if (hit_coeff) begin
            if (cwen_reg[1:0] == COEFF_WRITE_KEY && cbusy_cnt_reg == 16'h0000) begin
              coeff_we = 1'b1;
              cbusy_cnt_next = 16'(COEFF_WRITE_CYCLES);
            end
          end else if (addr_reg == OFF_TRANSPARENT) begin
            transp_next = 1'b1;
          end else if (addr_reg == OFF_SIMULTANEOUS) begin
            transp_next = 1'b0;
          end else if (addr_reg == OFF_UPDATE_TRIGGER) begin
            // Only the access matters, the data lanes are not looked at.
            upd_next = 1'b1;
            transp_next = 1'b0;
            out_latch_next = in_latch_reg;
          end else if (addr_reg == OFF_SOFT_RESET_CONTROL) begin
            if (!bs_n_reg[0]) begin
              ctrl_next[7:0] = wdata_reg[7:0];
            end
            if (!bs_n_reg[1]) begin
              ctrl_next[15:8] = wdata_reg[15:8];
            end
            srst_next = !bs_n_reg[0] && wdata_reg[CTRL_SOFT_RESET_BIT];
          end else if (addr_reg == OFF_COEFF_MEMORY_STATUS && !bs_n_reg[0]) begin
            cwen_next = wdata_reg[7:0];
          end
        end
        if (respond) begin
          ack_n_next = 1'b0;
          oe_n_next = !rd_reg;
          dout_next = rd_reg ? rdata : READ_ZERO;
          state_next = BUS_ACK;
        end else begin
          state_next = BUS_HOLD;
        end
      end
      BUS_ACK: begin
        state_next = BUS_HOLD;
      end
      BUS_HOLD: begin
        // Wait for the select to drop so one access is never taken twice.
        if (io_sel_n) begin
          state_next = BUS_IDLE;
        end
      end
    endcase
    // The software reset lands one cycle after its write, like a bus reset.
    if (srst_reg) begin
      transp_next = 1'b0;
      ctrl_next = CTRL_RESET;
      for (int i = 0; i < CHANNELS; i++) begin
        out_latch_next[i] = ZERO_VOLT_CODE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= BUS_IDLE;
      addr_reg <= 7'h00;
      rd_reg <= 1'b0;
      bs_n_reg <= 2'h3;
      wdata_reg <= 16'h0000;
      ack_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dout_reg <= READ_ZERO;
      transp_reg <= 1'b0;
      upd_reg <= 1'b0;
      srst_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      cwen_reg <= COEFF_WEN_RESET;
      cbusy_cnt_reg <= 16'h0000;
      for (int i = 0; i < CHANNELS; i++) begin
        out_latch_reg[i] <= ZERO_VOLT_CODE;
      end
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      bs_n_reg <= bs_n_next;
      wdata_reg <= wdata_next;
      ack_n_reg <= ack_n_next;
      oe_n_reg <= oe_n_next;
      dout_reg <= dout_next;
      transp_reg <= transp_next;
      upd_reg <= upd_next;
      srst_reg <= srst_next;
      ctrl_reg <= ctrl_next;
      cwen_reg <= cwen_next;
      cbusy_cnt_reg <= cbusy_cnt_next;
      out_latch_reg <= out_latch_next;
    end
  end

  // Input latches carry no reset, so stale data survives a reset.
  always_ff @(posedge clk) begin
    in_latch_reg <= in_latch_next;
  end

  // Per-channel serial transfer timers behind the write status word.
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_chan
      if (g < CHANNELS) begin : g_live
        logic [7:0] cnt_reg, cnt_next;
        always_comb begin
          cnt_next = cnt_reg;
          if (chan_start[g]) begin
            cnt_next = CHAN_XFER_CYC;
          end else if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        always_ff @(posedge clk) begin
          if (sys_rst) begin
            cnt_reg <= 8'h00;
          end else begin
            cnt_reg <= cnt_next;
          end
        end
        assign chan_ready[g] = (cnt_reg == 8'h00);
        assign dac_code[g*DAC_BITS +: DAC_BITS] = out_latch_reg[g];
      end else begin : g_absent
        assign chan_ready[g] = 1'b1;
      end
    end
  endgenerate

  assign ack_n = ack_n_reg;
  assign data_oe_n = oe_n_reg;
  assign data_out = dout_reg;
  assign update_pulse = upd_reg;
  assign transparent_mode = transp_reg;

endmodule
`default_nettype wire

// [tb/dac_update_ctrl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module dac_update_ctrl_checker
  import dac_ctrl_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int COEFF_WRITE_CYCLES = COEFF_WRITE_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic io_sel_n,
  input wire logic rd_wr,
  input wire logic [6:1] addr,
  input wire logic [1:0] byte_sel_n,
  input wire logic [15:0] data_in,
  input wire logic ack_n,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  // Converter side
  input wire logic [CHANNELS*DAC_BITS-1:0] dac_code,
  input wire logic update_pulse,
  input wire logic transparent_mode
);
  localparam logic [CHANNELS*DAC_BITS-1:0] ZALL = {CHANNELS{ZERO_VOLT_CODE}};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence start_wr(logic [6:0] off, logic extra);
    $fell(io_sel_n) && !rd_wr && {addr, 1'b0} == off && extra;
  endsequence
  sequence one_wait;
    ack_n [*2] ##1 !ack_n;
  endsequence
  trig_ack_a: assert property (start_wr(OFF_UPDATE_TRIGGER, 1'b1) |-> one_wait)
    else $error("trigger ack timing wrong");
  trig_pulse_a: assert property (start_wr(OFF_UPDATE_TRIGGER, 1'b1) |-> ##2 update_pulse)
    else $error("no update pulse");
  pulse_one_a: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse too long");
  trig_mode_a: assert property (start_wr(OFF_UPDATE_TRIGGER, 1'b1) |-> ##3 !transparent_mode)
    else $error("trigger left transparent mode");
  transp_sel_a: assert property (start_wr(OFF_TRANSPARENT, 1'b1) |-> ##3 transparent_mode)
    else $error("transparent select failed");
  sim_sel_a: assert property (start_wr(OFF_SIMULTANEOUS, 1'b1) |-> ##3 !transparent_mode)
    else $error("simultaneous select failed");
  no_read_ack_a: assert property ($fell(io_sel_n) && rd_wr && addr inside {6'h10, 6'h11, 6'h12}
    |=> ack_n [*6]) else $error("write-only place acked a read");
  coeff_read_a: assert property ($fell(io_sel_n) && rd_wr && addr >= 6'h20
    |-> ack_n [*2] ##1 (!ack_n && !data_oe_n)) else $error("coefficient read timing wrong");
  sim_hold_a: assert property ((!transparent_mode && !$past(transparent_mode) &&
    !update_pulse && dac_code != ZALL) |-> $stable(dac_code)) else $error("output moved");
  reset_val_a: assert property ($fell(sys_rst) |-> dac_code == ZALL && !transparent_mode)
    else $error("reset state wrong");
  soft_rst_a: assert property (start_wr(OFF_SOFT_RESET_CONTROL, !byte_sel_n[0] && data_in[7])
    |-> ##3 dac_code == ZALL && !transparent_mode) else $error("soft reset failed");
endmodule
bind dac_update_ctrl dac_update_ctrl_checker #(.CHANNELS(CHANNELS),
  .COEFF_WRITE_CYCLES(COEFF_WRITE_CYCLES)) u_chk (.clk, .sys_rst, .io_sel_n, .rd_wr,
  .addr, .byte_sel_n, .data_in, .ack_n, .data_out, .data_oe_n, .dac_code, .update_pulse,
  .transparent_mode);
`default_nettype wire

// [tb/dac_update_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module dac_update_ctrl_tb_top;
  import dac_ctrl_pkg::*;
  typedef struct packed {
    logic rw; logic [6:0] off; logic [1:0] bs; logic [15:0] d; logic [15:0] q; logic ok;
  } row_s;
  localparam row_s ROWS [11] = '{
    '{1, 7'h28, 2'h0, 16'h0000, 16'h0000, 1}, '{1, 7'h2A, 2'h0, 16'h0000, 16'h8000, 1},
    '{1, 7'h26, 2'h0, 16'h0000, 16'hFFFF, 1}, '{1, 7'h24, 2'h0, 16'h0000, 16'h0000, 0},
    '{1, 7'h20, 2'h0, 16'h0000, 16'h0000, 0}, '{1, 7'h22, 2'h0, 16'h0000, 16'h0000, 0},
    '{0, 7'h2B, 2'h2, 16'h0003, 16'h0000, 1}, '{1, 7'h2A, 2'h0, 16'h0000, 16'h8003, 1},
    '{0, 7'h28, 2'h1, 16'h8000, 16'h0000, 1}, '{1, 7'h28, 2'h0, 16'h0000, 16'h8000, 1},
    '{1, 7'h3E, 2'h0, 16'h0000, 16'h0000, 1}};
  logic clk;
  logic sys_rst;
  wire logic io_sel_n, rd_wr, ack_n, data_oe_n, update_pulse, transparent_mode;
  wire logic [6:1] addr;
  wire logic [1:0] byte_sel_n;
  wire logic [15:0] data_in, data_out;
  wire logic [16*DAC_BITS-1:0] dac_code;
  logic [15:0] q;
  logic ok;
  logic [11:0] lat [16];
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  dac_update_ctrl #(.CHANNELS(16), .COEFF_WRITE_CYCLES(20)) u_dac_update_ctrl (.clk, .sys_rst,
    .io_sel_n, .rd_wr, .addr, .byte_sel_n, .data_in, .ack_n, .data_out, .data_oe_n,
    .dac_code, .update_pulse, .transparent_mode);
  host_bus_model u_host_bus_model (.clk, .io_sel_n, .rd_wr, .addr, .byte_sel_n, .data_in,
    .ack_n, .data_out);
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic acc(input logic rw, input logic [6:0] off, input logic [1:0] bs,
      input logic [15:0] d);
    u_host_bus_model.access(rw, off, bs, d, q, ok);
  endtask
  // One selects the zero volt code, otherwise the tracked input latches.
  task automatic lanes(input logic z);
    for (int i = 0; i < 16; i++) begin
      cmp_word({4'h0, dac_code[i*DAC_BITS +: DAC_BITS]}, {4'h0, z ? ZERO_VOLT_CODE : lat[i]});
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    lanes(1'b1);
    cmp_bit(transparent_mode, 1'b0);
    foreach (ROWS[i]) begin
      acc(ROWS[i].rw, ROWS[i].off, ROWS[i].bs, ROWS[i].d);
      cmp_bit(ok, ROWS[i].ok);
      if (ROWS[i].rw) cmp_word(q, ROWS[i].q);
    end
    for (int i = 0; i < 16; i++) begin
      lat[i] = {4'(i), 8'h5A};
      u_host_bus_model.chan_write(i, lat[i]);
      if (i == 1) begin
        acc(1'b1, OFF_CHANNEL_WRITE_BUSY, 2'h0, 16'h0000);
        cmp_word(q, 16'hFFFC);
      end
    end
    lanes(1'b1);
    u_host_bus_model.wait_ready(OFF_CHANNEL_WRITE_BUSY, 15);
    acc(1'b0, OFF_SIMULTANEOUS, 2'h0, 16'h0000);
    acc(1'b0, OFF_UPDATE_TRIGGER, 2'h0, 16'hFFFF);
    lanes(1'b0);
    acc(1'b1, 7'h00, 2'h0, 16'h0000);
    cmp_word(q, {lat[0], 4'h0});
    acc(1'b0, OFF_TRANSPARENT, 2'h0, 16'h1234);
    cmp_bit(transparent_mode, 1'b1);
    lat[3] = 12'hC3C;
    u_host_bus_model.chan_write(3, lat[3]);
    lanes(1'b0);
    acc(1'b0, OFF_UPDATE_TRIGGER, 2'h0, 16'h0000);
    cmp_bit(transparent_mode, 1'b0);
    acc(1'b0, OFF_TRANSPARENT, 2'h0, 16'h0000);
    acc(1'b0, OFF_SIMULTANEOUS, 2'h0, 16'h0000);
    cmp_bit(transparent_mode, 1'b0);
    acc(1'b0, OFF_TRANSPARENT, 2'h0, 16'h0000);
    acc(1'b0, OFF_SOFT_RESET_CONTROL, 2'h2, 16'h0080);
    // The soft reset lands on the edge after the acknowledge, so look one cycle later.
    @(posedge clk);
    lanes(1'b1);
    cmp_bit(transparent_mode, 1'b0);
    acc(1'b1, OFF_SOFT_RESET_CONTROL, 2'h0, 16'h0000);
    cmp_word(q, CTRL_RESET);
    acc(1'b0, OFF_COEFF_MEMORY_STATUS, 2'h2, 16'h0003);
    acc(1'b0, OFF_COEFF_FIRST, 2'h2, 16'h00F1);
    acc(1'b1, OFF_COEFF_MEMORY_STATUS, 2'h0, 16'h0000);
    cmp_bit(q[COEFF_BUSY_BIT], 1'b0);
    u_host_bus_model.wait_ready(OFF_COEFF_MEMORY_STATUS, COEFF_BUSY_BIT);
    acc(1'b1, OFF_COEFF_FIRST, 2'h0, 16'h0000);
    cmp_word(q, 16'h00F1);
    acc(1'b0, OFF_COEFF_MEMORY_STATUS, 2'h2, 16'h0001);
    acc(1'b0, OFF_COEFF_FIRST, 2'h2, 16'h0020);
    u_host_bus_model.wait_ready(OFF_COEFF_MEMORY_STATUS, COEFF_BUSY_BIT);
    acc(1'b1, OFF_COEFF_FIRST, 2'h0, 16'h0000);
    cmp_word(q, 16'h00F1);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    lanes(1'b1);
    acc(1'b0, OFF_UPDATE_TRIGGER, 2'h0, 16'h0000);
    lanes(1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// [tb/host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic clk,
  // Host drive
  output logic io_sel_n,
  output logic rd_wr,
  output logic [6:1] addr,
  output logic [1:0] byte_sel_n,
  output logic [15:0] data_in,
  // Device answer
  input wire logic ack_n,
  input wire logic [15:0] data_out
);
  initial begin
    io_sel_n = 1'b1;
    rd_wr = 1'b1;
    addr = 6'h00;
    byte_sel_n = 2'h3;
    data_in = 16'h0000;
  end
  task automatic access(input logic rw, input logic [6:0] off, input logic [1:0] bs,
      input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk);
    io_sel_n <= 1'b0;
    rd_wr <= rw;
    addr <= off[6:1];
    byte_sel_n <= bs;
    data_in <= d;
    ok = 1'b0;
    q = 16'h0000;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clk);
      if (ack_n === 1'b0) begin
        ok = 1'b1;
        q = data_out;
      end
    end
    // A released bus shows inverted data so stale values cannot pass by luck.
    io_sel_n <= 1'b1;
    data_in <= ~d;
  endtask
  task automatic chan_write(input int ch, input logic [11:0] code);
    logic [15:0] q;
    logic ok;
    access(1'b0, 7'(ch * 2), 2'h0, {code, 4'hF}, q, ok);
  endtask
  // Polls a busy bit until ready, so no write lands inside a transfer.
  task automatic wait_ready(input logic [6:0] off, input int b);
    logic [15:0] q;
    logic ok;
    int n;
    for (n = 0; n < 200; n++) begin
      access(1'b1, off, 2'h0, 16'h0000, q, ok);
      if (q[b] === 1'b1) break;
    end
  endtask
endmodule
`default_nettype wire
